//--- core/bsw_pkg.sv
// Constants, types and helpers shared by the channel switch control block.
// Assumes a 100 MHz reference clock that samples the serial bus pins.
//
// Functional notes
// - External reset low clears channel register, protocol state, deselects all channels.
// - Power-on reset holds everything in reset, then defaults are loaded.
// - Data falling while clock high is a start; begins a transaction.
// - Address byte arrives most significant bit first, direction bit included.
// - Matching address is acknowledged by holding data low through ack clock high.
// - Data stable while clock high; a change there is start or stop.
// - Data rising while clock high is a stop; device detects it.
// - Each byte is followed by one ack bit; transmitter releases data line.
// - Device acks every written byte; master acks every read byte except the last.
// - Master not acking a read byte ends the read; device releases data.
// - Last address bit gives direction: 1 read, 0 write.
// - Own address is fixed upper bits plus three strap bits, 70h to 77h.
// - Byte after an acked write address is stored as channel select.
// - Channel select is writable and readable; reads return the stored byte.
// - Bit n enables downstream channel n; any combination allowed.
// - New channel selection takes effect only at a stop condition.
// - With several written bytes, only the last one is kept.
// - After power-up or reset the channel select reads all zeros.
package bsw_pkg;

    // Timing
    localparam int unsigned CLK_PERIOD_NS            = 10;
    localparam int unsigned MIN_RESET_PULSE_WIDTH_NS = 6;
    localparam int unsigned RESET_PULSE_CYC          =
        ((MIN_RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
        (MIN_RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Addressing and register layout
    localparam logic [3:0] ADDR_FIXED_HI     = 4'he;
    localparam logic       DIR_READ          = 1'b1;
    localparam logic [7:0] CHAN_SELECT_RESET = 8'h00;
    localparam logic [3:0] BIT_CNT_FULL      = 4'h8;

    // Pin filter reset value {strap[2:0], ext_rst_n, sda, scl}
    localparam logic [5:0] PIN_IDLE = 6'h07;

    typedef enum logic [2:0] {
        BSW_IDLE     = 3'b000,
        BSW_ADDR     = 3'b001,
        BSW_ADDR_ACK = 3'b011,
        BSW_WR_BYTE  = 3'b010,
        BSW_WR_ACK   = 3'b110,
        BSW_RD_BYTE  = 3'b111,
        BSW_RD_ACK   = 3'b101,
        BSW_IGNORE   = 3'b100
    } bsw_state_t;

    function automatic logic bsw_addr_match(input logic [6:0] addr, input logic [2:0] strap);
        return addr == {ADDR_FIXED_HI, strap};
    endfunction : bsw_addr_match

endpackage : bsw_pkg

//--- core/bsw_line_if.sv
// Filtered bus levels and detected bus events between the block's modules.
// Assumes all signals live in the reference clock domain.
`timescale 1ns/1ns
interface bsw_line_if;
    logic       scl;
    logic       sda;
    logic       ext_rst_n;
    logic [2:0] strap;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    modport filt (output scl, sda, ext_rst_n, strap);
    modport det  (input scl, sda, output scl_rise, scl_fall, start_det, stop_det);
    modport core (input scl, sda, ext_rst_n, strap, scl_rise, scl_fall, start_det, stop_det);
endinterface : bsw_line_if

//--- core/bsw_pin_filter.sv
// Two-flop synchronisers and single-sample glitch filter for the input pins.
// Assumes pins are asynchronous to ref_clk_i.
`timescale 1ns/1ns
module bsw_pin_filter (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // Raw pins {strap[2:0], ext_rst_n, sda, scl}
    input  wire logic [5:0] pins_i,
    // Filtered levels
    bsw_line_if.filt        ln
);
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] flt;
    } bsw_filt_t;

    bsw_filt_t q;
    bsw_filt_t d;

    always_comb begin
        d     = q;
        d.s1  = pins_i;
        d.s2  = q.s1;
        d.s3  = q.s2;
        d.flt = (q.flt & (q.s2 ^ q.s3)) | (q.s2 & ~(q.s2 ^ q.s3));
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{s1: bsw_pkg::PIN_IDLE, s2: bsw_pkg::PIN_IDLE, s3: bsw_pkg::PIN_IDLE, flt: bsw_pkg::PIN_IDLE};
        end else begin
            q <= d;
        end
    end

    assign ln.scl       = q.flt[0];
    assign ln.sda       = q.flt[1];
    assign ln.ext_rst_n = q.flt[2];
    assign ln.strap     = q.flt[5:3];

    AST_FILTER_NEEDS_TWO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (q.flt != $past(q.flt)) |-> ($past(q.s2) == $past(q.s3)))
        else $error("Filtered level changed on a single sample");

endmodule : bsw_pin_filter

//--- core/bsw_cond_detect.sv
// Bus clock edge and start/stop condition detector on filtered levels.
// Assumes filtered, glitch-free scl and sda in the reference domain.
`timescale 1ns/1ns
module bsw_cond_detect (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Levels in, events out
    bsw_line_if.det   ln
);
    typedef struct packed {
        logic scl_p;
        logic sda_p;
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } bsw_det_t;

    bsw_det_t q;
    bsw_det_t d;

    always_comb begin
        d       = q;
        d.scl_p = ln.scl;
        d.sda_p = ln.sda;
        d.rise  = ln.scl & ~q.scl_p;
        d.fall  = ~ln.scl & q.scl_p;
        d.start = ln.scl & q.scl_p & q.sda_p & ~ln.sda;
        d.stop  = ln.scl & q.scl_p & ~q.sda_p & ln.sda;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{scl_p: 1'b1, sda_p: 1'b1, rise: 1'b0, fall: 1'b0, start: 1'b0, stop: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign ln.scl_rise  = q.rise;
    assign ln.scl_fall  = q.fall;
    assign ln.start_det = q.start;
    assign ln.stop_det  = q.stop;

    AST_HIGH_CHANGE_IS_COND: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ln.scl && q.scl_p && (ln.sda != q.sda_p)) |=> (q.start || q.stop))
        else $error("Data change during clock high not flagged as start or stop");

endmodule : bsw_cond_detect

//--- core/bsw_switch_ctrl.sv
// Serial-bus target controlling eight downstream channel enables.
// Assumes an open-drain data pin resolved outside; channel enables drive pass gates.
`timescale 1ns/1ns
module bsw_switch_ctrl (
    // Clock and power-on reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // External reset pin
    input  wire logic       ext_reset_n_i,
    // Serial bus
    input  wire logic       bus_clk_i,
    input  wire logic       bus_data_i,
    output logic            bus_data_o,
    output logic            bus_data_oe_o,
    // Address straps
    input  wire logic       addr_strap_bit0_i,
    input  wire logic       addr_strap_bit1_i,
    input  wire logic       addr_strap_bit2_i,
    // Downstream channel enables
    output logic [7:0]      chan_enable_o
);
    typedef struct packed {
        bsw_pkg::bsw_state_t st;
        logic [3:0]          cnt;
        logic [7:0]          sh;
        logic [7:0]          tx;
        logic                rw;
        logic                nack;
        logic [7:0]          chan_sel;
        logic [7:0]          chan_en;
        logic                oe;
        logic                dout;
    } bsw_core_t;

    localparam bsw_core_t CORE_RESET = '{
        st:       bsw_pkg::BSW_IDLE,
        cnt:      4'h0,
        sh:       8'h00,
        tx:       8'h00,
        rw:       1'b0,
        nack:     1'b0,
        chan_sel: bsw_pkg::CHAN_SELECT_RESET,
        chan_en:  bsw_pkg::CHAN_SELECT_RESET,
        oe:       1'b0,
        dout:     1'b0
    };

    bsw_core_t q;
    bsw_core_t d;
    logic      addr_hit;

    bsw_line_if ln ();

    // Pin synchronisers and glitch filter
    bsw_pin_filter u_filter (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .pins_i    ({addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i,
                     ext_reset_n_i, bus_data_i, bus_clk_i}),
        .ln        (ln.filt)
    );

    // Edge and condition detector
    bsw_cond_detect u_detect (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .ln        (ln.det)
    );

    assign addr_hit = bsw_pkg::bsw_addr_match(q.sh[7:1], ln.strap);

    always_comb begin
        d = q;
        unique case (q.st)
            bsw_pkg::BSW_IDLE, bsw_pkg::BSW_IGNORE: begin
                d.oe = 1'b0;
            end
            bsw_pkg::BSW_ADDR: begin
                if (ln.scl_rise) begin
                    d.sh  = {q.sh[6:0], ln.sda};
                    d.cnt = q.cnt + 4'h1;
                end else if (ln.scl_fall && q.cnt == bsw_pkg::BIT_CNT_FULL) begin
                    d.cnt = 4'h0;
                    d.rw  = q.sh[0];
                    if (addr_hit) begin
                        d.oe = 1'b1;
                        d.st = bsw_pkg::BSW_ADDR_ACK;
                    end else begin
                        d.oe = 1'b0;
                        d.st = bsw_pkg::BSW_IGNORE;
                    end
                end
            end
            bsw_pkg::BSW_ADDR_ACK: begin
                if (ln.scl_fall) begin
                    d.cnt = 4'h0;
                    if (q.rw == bsw_pkg::DIR_READ) begin
                        d.tx = q.chan_sel;
                        d.oe = ~q.chan_sel[7];
                        d.st = bsw_pkg::BSW_RD_BYTE;
                    end else begin
                        d.oe = 1'b0;
                        d.st = bsw_pkg::BSW_WR_BYTE;
                    end
                end
            end
            bsw_pkg::BSW_WR_BYTE: begin
                if (ln.scl_rise) begin
                    d.sh  = {q.sh[6:0], ln.sda};
                    d.cnt = q.cnt + 4'h1;
                end else if (ln.scl_fall && q.cnt == bsw_pkg::BIT_CNT_FULL) begin
                    d.chan_sel = q.sh;
                    d.cnt      = 4'h0;
                    d.oe       = 1'b1;
                    d.st       = bsw_pkg::BSW_WR_ACK;
                end
            end
            bsw_pkg::BSW_WR_ACK: begin
                if (ln.scl_fall) begin
                    d.oe = 1'b0;
                    d.st = bsw_pkg::BSW_WR_BYTE;
                end
            end
            bsw_pkg::BSW_RD_BYTE: begin
                if (ln.scl_rise) begin
                    d.cnt = q.cnt + 4'h1;
                end else if (ln.scl_fall) begin
                    if (q.cnt == bsw_pkg::BIT_CNT_FULL) begin
                        d.cnt  = 4'h0;
                        d.oe   = 1'b0;
                        d.nack = 1'b0;
                        d.st   = bsw_pkg::BSW_RD_ACK;
                    end else begin
                        d.tx = {q.tx[6:0], 1'b0};
                        d.oe = ~q.tx[6];
                    end
                end
            end
            bsw_pkg::BSW_RD_ACK: begin
                if (ln.scl_rise) begin
                    d.nack = ln.sda;
                end else if (ln.scl_fall) begin
                    if (q.nack) begin
                        d.oe = 1'b0;
                        d.st = bsw_pkg::BSW_IGNORE;
                    end else begin
                        d.tx = q.chan_sel;
                        d.oe = ~q.chan_sel[7];
                        d.st = bsw_pkg::BSW_RD_BYTE;
                    end
                end
            end
        endcase
        if (ln.start_det) begin
            d.st  = bsw_pkg::BSW_ADDR;
            d.cnt = 4'h0;
            d.oe  = 1'b0;
        end
        if (ln.stop_det) begin
            d.st      = bsw_pkg::BSW_IDLE;
            d.oe      = 1'b0;
            d.chan_en = q.chan_sel;
        end
        if (!ln.ext_rst_n) begin
            d = CORE_RESET;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= CORE_RESET;
        end else begin
            q <= d;
        end
    end

    assign bus_data_o    = q.dout;
    assign bus_data_oe_o = q.oe;
    assign chan_enable_o = q.chan_en;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_EXT_RESET_CLEARS: assert property (
        !ln.ext_rst_n |=> (chan_enable_o == 8'h00) && !bus_data_oe_o && (q.chan_sel == 8'h00))
        else $error("External reset did not clear channels");

    AST_START_TO_ADDR: assert property (
        (ln.start_det && ln.ext_rst_n) |=> (q.st == bsw_pkg::BSW_ADDR) && (q.cnt == 4'h0))
        else $error("Start did not open address phase");

    AST_ADDR_ACK_LOW: assert property (
        (q.st == bsw_pkg::BSW_ADDR_ACK) |-> bus_data_oe_o && !bus_data_o)
        else $error("Address ack not driven low");

    AST_NO_ACK_FOREIGN: assert property (
        (q.st == bsw_pkg::BSW_ADDR && ln.scl_fall && q.cnt == bsw_pkg::BIT_CNT_FULL && !addr_hit
         && !ln.start_det && !ln.stop_det && ln.ext_rst_n)
        |=> (q.st == bsw_pkg::BSW_IGNORE) && !bus_data_oe_o)
        else $error("Foreign address acknowledged");

    AST_IGNORE_QUIET: assert property (
        (q.st == bsw_pkg::BSW_IGNORE) |-> !bus_data_oe_o)
        else $error("Data driven while ignoring bus");

    AST_MATCH_RANGE: assert property (
        (q.st == bsw_pkg::BSW_ADDR_ACK) |-> (q.sh[7:1] >= 7'h70) && (q.sh[7:1] <= 7'h77))
        else $error("Acked address outside own range");

    AST_READ_DIR: assert property (
        (q.st == bsw_pkg::BSW_ADDR_ACK && ln.scl_fall && q.rw && !ln.start_det && !ln.stop_det
         && ln.ext_rst_n)
        |=> (q.st == bsw_pkg::BSW_RD_BYTE) && (bus_data_oe_o == ~q.chan_sel[7]))
        else $error("Read direction did not present stored byte");

    AST_WRITE_STORE: assert property (
        (q.st == bsw_pkg::BSW_WR_BYTE && ln.scl_fall && q.cnt == bsw_pkg::BIT_CNT_FULL
         && !ln.start_det && !ln.stop_det && ln.ext_rst_n)
        |=> (q.chan_sel == $past(q.sh)) && bus_data_oe_o ##1 (q.st == bsw_pkg::BSW_WR_ACK))
        else $error("Written byte not stored or not acked");

    AST_APPLY_AT_STOP: assert property (
        (chan_enable_o != $past(chan_enable_o)) |-> ($past(ln.stop_det) || !$past(ln.ext_rst_n)))
        else $error("Channels changed without stop");

    AST_STOP_IDLE: assert property (
        (ln.stop_det && ln.ext_rst_n) |=> (q.st == bsw_pkg::BSW_IDLE) && !bus_data_oe_o
        && (chan_enable_o == $past(q.chan_sel)))
        else $error("Stop not honoured");

    AST_NACK_RELEASE: assert property (
        (q.st == bsw_pkg::BSW_RD_ACK && ln.scl_fall && q.nack && !ln.start_det && !ln.stop_det
         && ln.ext_rst_n) |=> !bus_data_oe_o [*2])
        else $error("Data line not released after nack");

    AST_WR_ACK_RELEASE: assert property (
        (q.st == bsw_pkg::BSW_WR_ACK && ln.scl_fall && !ln.start_det && !ln.stop_det && ln.ext_rst_n)
        |=> !bus_data_oe_o && (q.st == bsw_pkg::BSW_WR_BYTE))
        else $error("Ack not released after write byte");

    COV_WRITE: cover property (
        (q.st == bsw_pkg::BSW_WR_ACK) ##[1:1000] ln.stop_det);

    COV_READ_NACK: cover property (
        (q.st == bsw_pkg::BSW_RD_ACK) && ln.scl_fall && q.nack);

    COV_FOREIGN: cover property (
        (q.st == bsw_pkg::BSW_ADDR) ##1 (q.st == bsw_pkg::BSW_IGNORE));

    COV_MULTI_CHAN: cover property (
        ln.stop_det ##1 ($countones(chan_enable_o) > 1));

endmodule : bsw_switch_ctrl

//--- testbench/bsw_master_model.sv
// Behavioural upstream bus master driving clock and data lines.
// Assumes open-drain lines with pull-ups resolved by the bench; 80 ns bus clock period.
// Assumes calls start on a reference clock edge; every change is non-blocking on an edge.
`timescale 1ns/1ns
module bsw_master_model (
    // Bus lines driven by the master, 1 means released
    output logic      scl_o,
    output logic      sda_o,
    // Resolved data line
    input  wire logic sda_i
);
    // Target answers six reference clocks after a clock fall, so the low phase is long
    localparam int Q      = 20;
    localparam int T_LOW  = 60;
    localparam int T_HIGH = 20;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Start or repeated start, only from idle or after a finished byte
    // Clock rises only after the target has let go of a pending ack
    task automatic start_c();
        sda_o <= 1'b1;
        #(4*Q) scl_o <= 1'b1;
        #(2*Q) sda_o <= 1'b0;
        #(2*Q) scl_o <= 1'b0;
    endtask : start_c

    // Data held over the whole high phase, sampled late in it
    task automatic bit_c(input logic b, output logic s);
        #Q sda_o <= b;
        #(T_LOW-Q) scl_o <= 1'b1;
        #(T_HIGH-5) s = sda_i;
        #5 scl_o <= 1'b0;
    endtask : bit_c

    // Stop: data rises while clock is high
    task automatic stop_c();
        #Q sda_o <= 1'b0;
        #(T_LOW-Q) scl_o <= 1'b1;
        #(2*Q) sda_o <= 1'b1;
        #(4*Q);
    endtask : stop_c

    // Byte out most significant bit first, line released for the ack
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i], s);
        end
        bit_c(1'b1, s);
        ack = ~s;
    endtask : wbyte

    // Byte in, ack to continue or leave the line high on the last one
    task automatic rbyte(input logic last, output logic [7:0] d, output logic line);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, s);
            d[i] = s;
        end
        bit_c(last, line);
    endtask : rbyte
endmodule : bsw_master_model

//--- testbench/bsw_switch_ctrl_bench.sv
// Self-checking bench for the channel switch control block.
// Assumes the master model drives the bus; straps and resets driven here.
`timescale 1ns/1ns
module bsw_switch_ctrl_bench;
    logic       ref_clk;
    logic       rst_n;
    logic       ext_reset_n;
    logic [2:0] strap;
    logic       scl;
    logic       m_sda;
    logic       oe;
    logic       dout;
    logic [7:0] chan;
    wire        sda;
    int         err_count;
    int         compares;
    int         cyc;
    logic       ack;
    logic       line;
    logic [7:0] rd;
    logic [7:0] ch;

    // Open-drain data line with pull-up
    assign sda = m_sda & (oe ? dout : 1'b1);

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    bsw_switch_ctrl dut_u (
        .ref_clk_i         (ref_clk),
        .rst_n_i           (rst_n),
        .ext_reset_n_i     (ext_reset_n),
        .bus_clk_i         (scl),
        .bus_data_i        (sda),
        .bus_data_o        (dout),
        .bus_data_oe_o     (oe),
        .addr_strap_bit0_i (strap[0]),
        .addr_strap_bit1_i (strap[1]),
        .addr_strap_bit2_i (strap[2]),
        .chan_enable_o     (chan)
    );

    bsw_master_model m_u (
        .scl_o (scl),
        .sda_o (m_sda),
        .sda_i (sda)
    );

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    // Stop then let the pin pipeline settle
    task automatic end_txn();
        m_u.stop_c();
        repeat (6) @(posedge ref_clk);
    endtask : end_txn

    task automatic addr_txn(input logic [6:0] a, input logic dir, output logic ak);
        m_u.start_c();
        m_u.wbyte({a, dir}, ak);
    endtask : addr_txn

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        err_count = 0;
        compares = 0;
        cyc = 0;
        rst_n = 1'b0;
        ext_reset_n = 1'b1;
        strap = 3'h0;
        ch = 8'h00;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check("chan after reset", chan, 8'h00);
        addr_txn(7'h70, 1'b1, ack);
        check("read addr ack", {7'h00, ack}, 8'h01);
        m_u.rbyte(1'b1, rd, line);
        check("reset value", rd, 8'h00);
        end_txn();
        // Every strap value, a wrong address, then a one-hot channel
        for (int s = 0; s < 8; s++) begin
            @(posedge ref_clk);
            strap <= 3'(s);
            repeat (6) @(posedge ref_clk);
            addr_txn(7'h70 ^ 7'h01 ^ 7'(s), 1'b0, ack);
            check("foreign addr ack", {7'h00, ack}, 8'h00);
            m_u.wbyte(8'hff, ack);
            check("ignored byte ack", {7'h00, ack}, 8'h00);
            end_txn();
            check("chan after foreign", chan, ch);
            addr_txn(7'h70 | 7'(s), 1'b0, ack);
            check("own addr ack", {7'h00, ack}, 8'h01);
            m_u.wbyte(8'h01 << s, ack);
            check("data ack", {7'h00, ack}, 8'h01);
            check("chan before stop", chan, ch);
            end_txn();
            ch = 8'h01 << s;
            check("chan one hot", chan, ch);
        end
        addr_txn(7'h77, 1'b0, ack);
        m_u.wbyte(8'h3c, ack);
        m_u.wbyte(8'ha5, ack);
        check("second data ack", {7'h00, ack}, 8'h01);
        end_txn();
        check("last byte kept", chan, 8'ha5);
        addr_txn(7'h77, 1'b0, ack);
        m_u.wbyte(8'h5a, ack);
        addr_txn(7'h77, 1'b1, ack);
        check("restart read ack", {7'h00, ack}, 8'h01);
        m_u.rbyte(1'b0, rd, line);
        check("read byte one", rd, 8'h5a);
        m_u.rbyte(1'b1, rd, line);
        check("read byte two", rd, 8'h5a);
        check("line released at nack", {7'h00, line}, 8'h01);
        check("chan mid txn", chan, 8'ha5);
        end_txn();
        check("chan after read stop", chan, 8'h5a);
        @(posedge ref_clk);
        ext_reset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        ext_reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check("chan after pin reset", chan, 8'h00);
        addr_txn(7'h77, 1'b1, ack);
        m_u.rbyte(1'b1, rd, line);
        check("reg after pin reset", rd, 8'h00);
        end_txn();
        addr_txn(7'h77, 1'b0, ack);
        m_u.wbyte(8'h0f, ack);
        end_txn();
        check("chan before por", chan, 8'h0f);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("chan during por", chan, 8'h00);
        rst_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        addr_txn(7'h77, 1'b1, ack);
        m_u.rbyte(1'b1, rd, line);
        check("reg after por", rd, 8'h00);
        end_txn();
        stop_test();
    end
endmodule : bsw_switch_ctrl_bench
